//--- verif/csp_card_model.sv
// Purpose: card seated in each socket
// Assumes: st = seat b, seat a, io, ready, wp, aux1, aux0
// Notes: empty socket leaves pull levels on detect, ready and wp; aux lines still follow st[1:0]
`timescale 1ns/1ps
module csp_card_model (
	// card state per socket
	input wire logic [1:0][6:0] st,
	// card pins per socket
	output logic [1:0] ready_pin,
	output logic [1:0] wp_pin,
	output logic [1:0] detect_a_pin_n,
	output logic [1:0] detect_b_pin_n,
	output logic [1:0] battery_sense_a,
	output logic [1:0] battery_sense_b,
	output logic [1:0] card_audio_out,
	output logic [1:0] card_status_change
);
	// pins follow the card, aux lines by card kind
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			detect_b_pin_n[s] = !st[s][6];
			detect_a_pin_n[s] = !st[s][5];
			ready_pin[s] = |st[s][6:5] & st[s][3];
			wp_pin[s] = |st[s][6:5] & st[s][2];
			{battery_sense_b[s], battery_sense_a[s]} = st[s][4] ? 2'h0 : st[s][1:0];
			{card_audio_out[s], card_status_change[s]} = st[s][4] ? st[s][1:0] : 2'h0;
		end
	end
endmodule // csp_card_model

//--- verif/csp_regs_chk.sv
// Purpose: port checker for the socket registers
// Assumes: bound into csp_regs, one clock
// Notes: socket 0 supplies watched
`timescale 1ns/1ps
module csp_regs_chk #(
	parameter int SOCKETS = 2
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// host access
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic mem_sock,
	input wire logic [11:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_rvalid,
	input wire logic idx_rd,
	input wire logic idx_rvalid,
	// socket supplies
	input wire logic [SOCKETS-1:0] socket_output_gate,
	input wire logic [SOCKETS-1:0] socket_vcc_on,
	input wire logic [SOCKETS-1:0] socket_vcc_level,
	input wire logic [2*SOCKETS-1:0] socket_vpp_sel
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// gate bit written to socket A
	sequence s_gate_wr;
		mem_wr && !mem_sock && mem_addr == 12'h802 && mem_wdata[7];
	endsequence
	// answer of a memory read at one offset
	sequence s_ans(ofs);
		mem_rvalid && $past(mem_addr) == ofs;
	endsequence
	property p_mem_ans;
		mem_rd |=> mem_rvalid;
	endproperty
	a_mem_ans: assert property (p_mem_ans) else $error("no mem answer");
	property p_idx_ans;
		idx_rd |=> idx_rvalid;
	endproperty
	a_idx_ans: assert property (p_idx_ans) else $error("no idx answer");
	property p_st_top;
		s_ans(12'h801) |-> mem_rdata[7] == 1'b0;
	endproperty
	a_st_top: assert property (p_st_top) else $error("status bit 7 set");
	property p_pc_reserved_bits;
		s_ans(12'h802) |-> (mem_rdata & 8'h4C) == 8'h00;
	endproperty
	a_pc_reserved_bits: assert property (p_pc_reserved_bits) else $error("reserved bits set");
	property p_vpp_gate;
		!socket_vcc_on[0] |-> socket_vpp_sel[1:0] == 2'h0;
	endproperty
	a_vpp_gate: assert property (p_vpp_gate) else $error("vpp without vcc");
	property p_vpp_reserved_bits;
		socket_vpp_sel[1:0] != 2'h3;
	endproperty
	a_vpp_reserved_bits: assert property (p_vpp_reserved_bits) else $error("reserved vpp out");
	property p_level;
		socket_vcc_level[0] |-> socket_vcc_on[0];
	endproperty
	a_level: assert property (p_level) else $error("level without vcc");
	property p_gate;
		s_gate_wr |-> ##[1:2] socket_output_gate[0];
	endproperty
	a_gate: assert property (p_gate) else $error("gate not set");
	// status power flag of socket A matches its vcc output
	property p_pwr_stat;
		mem_rvalid && $past(mem_addr) == 12'h801 && !$past(mem_sock)
			|-> mem_rdata[6] == $past(socket_vcc_on[0]);
	endproperty
	a_pwr_stat: assert property (p_pwr_stat) else $error("power flag differs");
endmodule // csp_regs_chk

bind csp_regs csp_regs_chk #(.SOCKETS(SOCKETS)) chk_i (
	.mclk(mclk),
	.rst(rst),
	.mem_rd(mem_rd),
	.mem_wr(mem_wr),
	.mem_sock(mem_sock),
	.mem_addr(mem_addr),
	.mem_wdata(mem_wdata),
	.mem_rdata(mem_rdata),
	.mem_rvalid(mem_rvalid),
	.idx_rd(idx_rd),
	.idx_rvalid(idx_rvalid),
	.socket_output_gate(socket_output_gate),
	.socket_vcc_on(socket_vcc_on),
	.socket_vcc_level(socket_vcc_level),
	.socket_vpp_sel(socket_vpp_sel)
);

//--- verif/csp_regs_tb_top.sv
// Purpose: self-checking bench for csp_regs
// Assumes: card model drives pins
// Notes: table of card states, then power and resets
`timescale 1ns/1ps
module csp_regs_tb_top;
	typedef struct packed {logic [6:0] st; logic [7:0] exp;} csp_row_t;
	logic mclk, rst, global_reset_n, bus_reset_n, power_mgmt_event_en;
	logic mem_rd, mem_wr, mem_sock, idx_rd, idx_wr, vcc_level_select, mem_rvalid, idx_rvalid;
	logic [11:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata, idx_addr, idx_wdata, idx_rdata, q;
	logic [1:0] ready_pin, wp_pin, detect_a_pin_n, detect_b_pin_n, battery_sense_a;
	logic [1:0] battery_sense_b, card_audio_out, card_status_change;
	logic [1:0] socket_output_gate, socket_vcc_on, socket_vcc_level;
	logic [3:0] socket_vpp_sel;
	logic [1:0][6:0] st;
	int n_errors = 0, n_compared = 0;
	// card state beside expected status
	csp_row_t rows [7] = '{'{7'h00, 8'h00}, '{7'h6B, 8'h2F}, '{7'h26, 8'h16},
		'{7'h59, 8'h29}, '{7'h76, 8'h1E}, '{7'h60, 8'h0C}, '{7'h61, 8'h0D}};
	csp_regs #(.SOCKETS(2)) dut (
		.mclk(mclk), .rst(rst), .global_reset_n(global_reset_n), .bus_reset_n(bus_reset_n),
		.power_mgmt_event_en(power_mgmt_event_en),
		.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_sock(mem_sock), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
		.idx_rd(idx_rd), .idx_wr(idx_wr), .idx_addr(idx_addr), .idx_wdata(idx_wdata),
		.idx_rdata(idx_rdata), .idx_rvalid(idx_rvalid),
		.vcc_level_select(vcc_level_select), .io_card_mode({st[1][4], st[0][4]}),
		.ready_pin(ready_pin), .wp_pin(wp_pin), .detect_a_pin_n(detect_a_pin_n),
		.detect_b_pin_n(detect_b_pin_n), .battery_sense_a(battery_sense_a),
		.battery_sense_b(battery_sense_b), .card_audio_out(card_audio_out),
		.card_status_change(card_status_change),
		.socket_output_gate(socket_output_gate), .socket_vcc_on(socket_vcc_on),
		.socket_vcc_level(socket_vcc_level), .socket_vpp_sel(socket_vpp_sel));
	csp_card_model card (
		.st(st), .ready_pin(ready_pin), .wp_pin(wp_pin), .detect_a_pin_n(detect_a_pin_n),
		.detect_b_pin_n(detect_b_pin_n), .battery_sense_a(battery_sense_a),
		.battery_sense_b(battery_sense_b), .card_audio_out(card_audio_out),
		.card_status_change(card_status_change));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one access, held over its sampling edge
	task automatic acc(input bit ix, input bit w, input logic s, input logic [11:0] a,
		input logic [7:0] wd);
		@(negedge mclk);
		{mem_sock, mem_addr, mem_wdata, idx_addr, idx_wdata} = {s, a, wd, a[7:0], wd};
		if (ix) {idx_rd, idx_wr} = {!w, w};
		else {mem_rd, mem_wr} = {!w, w};
		@(negedge mclk);
		{mem_rd, mem_wr, idx_rd, idx_wr} = 4'h0;
		q = ix ? idx_rdata : mem_rdata;
		if (!w) chk({7'h0, ix ? idx_rvalid : mem_rvalid}, 8'h01);
	endtask
	// register r of socket s on both paths
	task automatic rd2(input logic s, input logic [7:0] r, input logic [7:0] exp);
		acc(0, 0, s, 12'h801 + r, 8'h00);
		chk(q, exp);
		acc(1, 0, s, {5'h00, s, 6'h01} + r, 8'h00);
		chk(q, exp);
	endtask
	// socket A supplies after settling
	task automatic outs(input logic [7:0] e);
		repeat (4) @(negedge mclk);
		chk({3'h0, socket_output_gate[0], socket_vcc_on[0], socket_vcc_level[0],
			socket_vpp_sel[1:0]}, e);
	endtask
	task automatic pulse(input bit g);
		@(negedge mclk);
		if (g) global_reset_n = 1'b0;
		else bus_reset_n = 1'b0;
		@(negedge mclk);
		{global_reset_n, bus_reset_n} = 2'h3;
	endtask
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		test_done;
	end
	initial begin
		{rst, global_reset_n, bus_reset_n, power_mgmt_event_en} = 4'hE;
		{mem_rd, mem_wr, idx_rd, idx_wr, vcc_level_select, mem_sock} = 6'h00;
		{mem_addr, mem_wdata, idx_addr, idx_wdata} = 36'h0;
		st = 14'h0000;
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		for (int s = 0; s < 2; s++) begin
			rd2(s[0], 8'h00, 8'h00);
			rd2(s[0], 8'h01, 8'h00);
		end
		$display("test reset done");
		foreach (rows[i]) begin
			for (int s = 0; s < 2; s++) begin
				st = 14'h0000;
				st[s] = rows[i].st;
				outs(8'h00);
				rd2(s[0], 8'h00, rows[i].exp);
				rd2(!s[0], 8'h00, 8'h00);
			end
		end
		$display("test table done");
		st = 14'h006B;
		acc(0, 1, 0, 12'h802, 8'hFF);
		rd2(0, 8'h01, 8'hB3);
		outs(8'h18);
		rd2(0, 8'h00, 8'h6F);
		rd2(1, 8'h01, 8'h00);
		acc(0, 1, 0, 12'h801, 8'h00);
		rd2(0, 8'h00, 8'h6F);
		vcc_level_select = 1'b1;
		acc(1, 1, 0, 12'h002, 8'hB2);
		outs(8'h1E);
		st = 14'h0026;
		outs(8'h10);
		acc(1, 1, 0, 12'h002, 8'h91);
		outs(8'h1D);
		acc(0, 1, 0, 12'h802, 8'h01);
		outs(8'h00);
		$display("test power done");
		acc(0, 1, 0, 12'h802, 8'hB1);
		power_mgmt_event_en = 1'b1;
		pulse(0);
		rd2(0, 8'h01, 8'hA0);
		pulse(1);
		rd2(0, 8'h01, 8'h00);
		power_mgmt_event_en = 1'b0;
		acc(0, 1, 0, 12'h802, 8'hB1);
		pulse(0);
		rd2(0, 8'h01, 8'h00);
		$display("test resets done");
		// socket B supplies through the index path, socket A left alone
		st = {7'h6B, 7'h00};
		acc(1, 1, 1, 12'h042, 8'h91);
		repeat (4) @(negedge mclk);
		chk({3'h0, socket_output_gate[1], socket_vcc_on[1], socket_vcc_level[1],
			socket_vpp_sel[3:2]}, 8'h1D);
		outs(8'h00);
		rd2(1, 8'h00, 8'h6F);
		rd2(1, 8'h01, 8'h91);
		$display("test socket b done");
		test_done;
	end
endmodule // csp_regs_tb_top

//--- verilog/csp_cfg.svh
// Purpose: constants for the card socket status and power registers
// Assumes: included by bare name from the register design file only, not the package
// Notes: offsets are per-socket; memory offsets sit inside one socket window
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

// memory-window offsets inside one socket window
`define CSP_MEM_STATUS_OFS 12'h801
`define CSP_MEM_POWER_OFS 12'h802
// legacy index offsets for socket A and socket B
`define CSP_IDX_STATUS_A 8'h01
`define CSP_IDX_STATUS_B 8'h41
`define CSP_IDX_POWER_A 8'h02
`define CSP_IDX_POWER_B 8'h42
// legacy index bit that picks socket B
`define CSP_IDX_SOCK_BIT 6

// status register bit positions
`define CSP_ST_RESERVED_BITS 7
`define CSP_ST_POWERED 6
`define CSP_ST_READY 5
`define CSP_ST_WP 4
`define CSP_ST_DET_B 3
`define CSP_ST_DET_A 2
`define CSP_ST_LEVEL_HI 1
`define CSP_ST_LEVEL_LO 0
`define CSP_ST_RESET 8'h00

// power control bit positions
`define CSP_PC_GATE 7
`define CSP_PC_AUTO 5
`define CSP_PC_VCC 4
`define CSP_PC_VPP_HI 1
`define CSP_PC_VPP_LO 0
`define CSP_PC_RESET 8'h00

// programming-voltage request codes
`define CSP_VPP_NONE 2'h0
`define CSP_VPP_VCC 2'h1
`define CSP_VPP_12V 2'h2
`define CSP_VPP_RESERVED_BITS 2'h3

// per-socket synchroniser lane: detect pins idle high (no card)
`define CSP_SYNC_LANE_W 8
`define CSP_SYNC_LANE_INIT 8'h0C

`endif

//--- verilog/csp_pkg.sv
// Purpose: shared types for the card socket register block
// Assumes: nothing from csp_cfg.svh; the enum needs no numbers
// Notes: types only
package csp_pkg;
	// register selected by a decoded access
	typedef enum logic [1:0] {
		CSP_REG_NONE,
		CSP_REG_STATUS,
		CSP_REG_POWER
	} csp_reg_t;
endpackage

//--- verilog/csp_regs.sv
// Purpose: per-socket interface status and power control registers
// Assumes: access strobes and pins synchronous to mclk except card pins
// Notes: reads answer one cycle after the strobe with a valid pulse
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_regs
	import csp_pkg::*;
#(
	parameter int SOCKETS = 2
) (
	// clock and resets
	input wire logic mclk,
	input wire logic rst,
	input wire logic global_reset_n,
	input wire logic bus_reset_n,
	input wire logic power_mgmt_event_en,
	// memory-window access
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic mem_sock,
	input wire logic [11:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	output logic mem_rvalid,
	// legacy index access
	input wire logic idx_rd,
	input wire logic idx_wr,
	input wire logic [7:0] idx_addr,
	input wire logic [7:0] idx_wdata,
	output logic [7:0] idx_rdata,
	output logic idx_rvalid,
	// system-level settings: one shared vcc level select, card mode per socket
	input wire logic vcc_level_select,
	input wire logic [SOCKETS-1:0] io_card_mode,
	// raw card pins per socket
	input wire logic [SOCKETS-1:0] ready_pin,
	input wire logic [SOCKETS-1:0] wp_pin,
	input wire logic [SOCKETS-1:0] detect_a_pin_n,
	input wire logic [SOCKETS-1:0] detect_b_pin_n,
	input wire logic [SOCKETS-1:0] battery_sense_a,
	input wire logic [SOCKETS-1:0] battery_sense_b,
	input wire logic [SOCKETS-1:0] card_audio_out,
	input wire logic [SOCKETS-1:0] card_status_change,
	// socket power and output controls
	output logic [SOCKETS-1:0] socket_output_gate,
	output logic [SOCKETS-1:0] socket_vcc_on,
	output logic [SOCKETS-1:0] socket_vcc_level,
	output logic [2*SOCKETS-1:0] socket_vpp_sel
);
	localparam int LW = `CSP_SYNC_LANE_W;

	// refuse socket counts the index map cannot reach
	if (SOCKETS < 1 || SOCKETS > 2) begin : g_bad_sockets
		$error("csp_regs: SOCKETS must be 1 or 2");
	end

	// decode a memory-window offset
	function automatic csp_reg_t decode_mem(input logic [11:0] ofs);
		csp_reg_t r;
		r = CSP_REG_NONE;
		if (ofs == `CSP_MEM_STATUS_OFS)
			r = CSP_REG_STATUS;
		else if (ofs == `CSP_MEM_POWER_OFS)
			r = CSP_REG_POWER;
		return r;
	endfunction

	// decode a legacy index, socket bit masked out
	function automatic csp_reg_t decode_idx(input logic [7:0] idx);
		csp_reg_t r;
		logic [7:0] base;
		r = CSP_REG_NONE;
		base = idx & ~(8'h01 << `CSP_IDX_SOCK_BIT);
		if (base == `CSP_IDX_STATUS_A)
			r = CSP_REG_STATUS;
		else if (base == `CSP_IDX_POWER_A)
			r = CSP_REG_POWER;
		return r;
	endfunction

	// raw and settled pin lanes, one lane per socket
	logic [LW*SOCKETS-1:0] raw_pins;
	logic [LW*SOCKETS-1:0] sync_pins;

	// per-socket register fields
	logic [SOCKETS-1:0] auto_power_switch_on; // switch by detects
	logic [SOCKETS-1:0] socket_vcc_enable; // vcc requested
	logic [1:0] prog_voltage_request [SOCKETS]; // vpp request code
	logic [7:0] status_reg [SOCKETS]; // live status image

	// decoded accesses
	csp_reg_t mem_reg; // register hit by memory path
	csp_reg_t idx_reg; // register hit by index path
	logic idx_sock; // socket picked by index
	logic [SOCKETS-1:0] pow_wr; // power write per socket
	logic [7:0] pow_wdata; // data for that write

	// reset classes
	logic ctx_clear; // clears context bits
	logic plain_clear; // clears the other bits

	// context bits survive bus reset while events are enabled
	always_comb begin
		ctx_clear = rst || !global_reset_n || (!power_mgmt_event_en && !bus_reset_n);
		plain_clear = rst || !global_reset_n || !bus_reset_n;
	end

	// socket lanes, socket 0 in the low lane
	genvar gs;
	for (gs = 0; gs < SOCKETS; gs++) begin : g_lane
		assign raw_pins[LW*gs +: LW] = {
			card_status_change[gs], card_audio_out[gs],
			battery_sense_b[gs], battery_sense_a[gs],
			detect_b_pin_n[gs], detect_a_pin_n[gs],
			wp_pin[gs], ready_pin[gs]};
	end

	// card pins are asynchronous to mclk
	csp_sync #(
		.WIDTH(LW * SOCKETS),
		.INIT({SOCKETS{`CSP_SYNC_LANE_INIT}})
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.raw(raw_pins),
		.settled(sync_pins)
	);

	// decode both access paths
	always_comb begin
		mem_reg = decode_mem(mem_addr);
		idx_reg = decode_idx(idx_addr);
		idx_sock = idx_addr[`CSP_IDX_SOCK_BIT];
		pow_wdata = mem_wdata;
		pow_wr = '0;
		// memory path wins a same-cycle collision
		if (mem_wr && mem_reg == CSP_REG_POWER) begin
			pow_wr[mem_sock] = 1'b1;
		end else if (idx_wr && idx_reg == CSP_REG_POWER) begin
			pow_wr[idx_sock] = 1'b1;
			pow_wdata = idx_wdata;
		end
	end

	// per-socket registers and power outputs
	for (gs = 0; gs < SOCKETS; gs++) begin : g_sock
		logic [LW-1:0] pins; // settled lane
		logic det_a; // first detect, active high
		logic det_b; // second detect, active high
		logic next_vcc_on; // effective vcc
		logic [1:0] next_vpp; // effective vpp

		assign pins = sync_pins[LW*gs +: LW];
		assign det_a = !pins[2];
		assign det_b = !pins[3];

		// effective supplies from the control fields
		always_comb begin
			next_vcc_on = socket_vcc_enable[gs];
			if (auto_power_switch_on[gs])
				next_vcc_on = socket_vcc_enable[gs] && det_a && det_b;
			next_vpp = `CSP_VPP_NONE;
			if (next_vcc_on && prog_voltage_request[gs] != `CSP_VPP_RESERVED_BITS)
				next_vpp = prog_voltage_request[gs];
		end

		// output gate and auto switch are context bits
		always_ff @(posedge mclk) begin
			if (ctx_clear) begin
				socket_output_gate[gs] <= 1'b0;
				auto_power_switch_on[gs] <= 1'b0;
			end else if (pow_wr[gs]) begin
				socket_output_gate[gs] <= pow_wdata[`CSP_PC_GATE];
				auto_power_switch_on[gs] <= pow_wdata[`CSP_PC_AUTO];
			end
		end

		// vcc enable and vpp request clear on any reset
		always_ff @(posedge mclk) begin
			if (plain_clear) begin
				socket_vcc_enable[gs] <= 1'b0;
				prog_voltage_request[gs] <= `CSP_VPP_NONE;
			end else if (pow_wr[gs]) begin
				socket_vcc_enable[gs] <= pow_wdata[`CSP_PC_VCC];
				prog_voltage_request[gs] <=
					pow_wdata[`CSP_PC_VPP_HI:`CSP_PC_VPP_LO];
			end
		end

		// registered supply outputs
		always_ff @(posedge mclk) begin
			if (plain_clear) begin
				socket_vcc_on[gs] <= 1'b0;
				socket_vcc_level[gs] <= 1'b0;
				socket_vpp_sel[2*gs +: 2] <= `CSP_VPP_NONE;
			end else begin
				socket_vcc_on[gs] <= next_vcc_on;
				socket_vcc_level[gs] <= vcc_level_select && next_vcc_on;
				socket_vpp_sel[2*gs +: 2] <= next_vpp;
			end
		end

		// live status image, refreshed every edge
		always_ff @(posedge mclk) begin
			if (rst) begin
				status_reg[gs] <= `CSP_ST_RESET;
			end else begin
				status_reg[gs][`CSP_ST_RESERVED_BITS] <= 1'b0;
				status_reg[gs][`CSP_ST_POWERED] <= next_vcc_on;
				status_reg[gs][`CSP_ST_READY] <= pins[0];
				status_reg[gs][`CSP_ST_WP] <= pins[1];
				status_reg[gs][`CSP_ST_DET_B] <= det_b;
				status_reg[gs][`CSP_ST_DET_A] <= det_a;
				if (io_card_mode[gs]) begin
					// i/o card: audio high, status change low
					status_reg[gs][`CSP_ST_LEVEL_HI] <= pins[6];
					status_reg[gs][`CSP_ST_LEVEL_LO] <= pins[7];
				end else begin
					// memory card: second sense high, first low
					status_reg[gs][`CSP_ST_LEVEL_HI] <= pins[5];
					status_reg[gs][`CSP_ST_LEVEL_LO] <= pins[4];
				end
			end
		end
	end

	// read value of one register of one socket
	function automatic logic [7:0] read_val(input csp_reg_t r, input logic s);
		logic [7:0] v;
		v = 8'h00;
		if (s < SOCKETS) begin
			case (r)
				CSP_REG_STATUS: begin
					v = status_reg[s];
				end
				CSP_REG_POWER: begin
					// reserved bits stay zero
					v[`CSP_PC_GATE] = socket_output_gate[s];
					v[`CSP_PC_AUTO] = auto_power_switch_on[s];
					v[`CSP_PC_VCC] = socket_vcc_enable[s];
					v[`CSP_PC_VPP_HI:`CSP_PC_VPP_LO] = prog_voltage_request[s];
				end
				default: begin
					v = 8'h00; // unmapped reads zero
				end
			endcase
		end
		return v;
	endfunction

	// memory-path read answer, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			mem_rdata <= 8'h00;
			mem_rvalid <= 1'b0;
		end else begin
			mem_rvalid <= mem_rd;
			if (mem_rd)
				mem_rdata <= read_val(mem_reg, mem_sock);
		end
	end

	// index-path read answer, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			idx_rdata <= 8'h00;
			idx_rvalid <= 1'b0;
		end else begin
			idx_rvalid <= idx_rd;
			if (idx_rd)
				idx_rdata <= read_val(idx_reg, idx_sock);
		end
	end
endmodule // csp_regs

//--- verilog/csp_sync.sv
// Purpose: two-stage synchroniser for the raw card pins
// Assumes: one clock, synchronous active-high reset
// Notes: the first stage is read by the second stage only
`timescale 1ns/1ps
module csp_sync #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// raw and settled pins
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] settled
);
	logic [WIDTH-1:0] stage1; // metastability catcher

	// both stages shift every edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1 <= INIT;
			settled <= INIT;
		end else begin
			stage1 <= raw;
			settled <= stage1;
		end
	end
endmodule // csp_sync
